// ---- logic/wdtlp_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Three-bit timeout select in low bits of the timeout register, eight periods.
// - Upper five bits read undetermined; software never writes ones there.
// - Select resets to 000; upper bits undefined.
// - Counter frozen during power-down; no service needed.
// - Wake interrupt not serviced until the line returns high.
// - After wake, counter stays stopped while the line is low.
// - In idle the counter keeps counting.
// - Disabled after reset; 1E then E1 enables and services; no disable.
// - Enabled counter advances each cycle, overflows at 3FFF, not accessible.
// - Overflow resets the device with a 96-cycle active-low reset pulse.
// - Seven-stage prescaler extends timeout, depth set by select field.
module wdtlp_top
  import wdtlp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        ext_int_n,
  input  wire logic        ext_int_enabled,
  output logic             int_service_req,
  output logic             core_clk_en,
  output var  logic        reset_pin_n
);
  // ****************************************
  // Bus decode
  // ****************************************
  wdtlp_apb_req_t req;
  logic           wr_en;
  logic           rd_en;
  logic           hit_key;
  logic           hit_sel;
  logic           hit_pwr;
  logic           mapped;

  // Request bundle and strobes
  always_comb
  begin
    req     = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    hit_key = (req.paddr == SERVICE_KEY_ADDR);
    hit_sel = (req.paddr == TIMEOUT_SEL_ADDR);
    hit_pwr = (req.paddr == POWER_CTRL_ADDR);
    mapped  = hit_key | hit_sel | hit_pwr;
    wr_en   = req.psel & req.penable & req.pwrite;
    rd_en   = req.psel & req.penable & !req.pwrite;
  end

  // Zero-wait slave; unmapped or key read gives error
  assign pready  = 1'b1;
  assign pslverr = req.psel & req.penable & (!mapped | (hit_key & !req.pwrite));

  // ****************************************
  // Registers and state
  // ****************************************
  logic [2:0]  code_q;
  wdtlp_pwr_t  pwr_q;
  logic        enabled_q;
  wdtlp_key_t  key_q;
  logic        service;
  logic        int_level;
  logic        overflow;
  logic        run;
  logic [6:0]  pulse_cnt_q;
  logic        pulse_on_q;
  logic        wd_rst_n;

  // Timeout select, low three bits only
  always_ff @(posedge pclk or negedge wd_rst_n)
    if (!wd_rst_n)
      code_q <= CODE_RESET;
    else if (wr_en && hit_sel)
      code_q <= req.pwdata[CODE_W-1:0];

  // Service key sequence; second key must follow first
  always_ff @(posedge pclk or negedge wd_rst_n)
    if (!wd_rst_n)
      key_q <= KEY_IDLE;
    else if (wr_en && hit_key)
    begin
      case (key_q)
        KEY_IDLE:  key_q <= (req.pwdata[7:0] == KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
        KEY_ARMED: key_q <= (req.pwdata[7:0] == KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
        default:   key_q <= KEY_IDLE;
      endcase
    end

  assign service = wr_en && hit_key && (key_q == KEY_ARMED) &&
                   (req.pwdata[7:0] == KEY_SECOND);

  // One-time enable, cleared only by reset
  always_ff @(posedge pclk or negedge wd_rst_n)
    if (!wd_rst_n)
      enabled_q <= 1'b0;
    else if (service)
      enabled_q <= 1'b1;

  // External interrupt line, synchronised
  wdtlp_pin_sync u_int_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (ext_int_n),
    .level_q (int_level)
  );

  // Power modes: software sets, hardware exit
  always_ff @(posedge pclk or negedge wd_rst_n)
    if (!wd_rst_n)
      pwr_q <= '0;
    else if (pwr_q.power_down)
    begin
      if (!int_level && ext_int_enabled)
      begin
        pwr_q.power_down <= 1'b0;
        pwr_q.idle       <= 1'b0;
        pwr_q.wake_hold  <= 1'b1;
      end
    end
    else if (pwr_q.wake_hold)
    begin
      if (int_level)
        pwr_q.wake_hold <= 1'b0;
    end
    else if (pwr_q.idle && !int_level)
      pwr_q.idle <= 1'b0;
    else if (wr_en && hit_pwr)
    begin
      pwr_q.power_down <= req.pwdata[PD_BIT];
      pwr_q.idle       <= req.pwdata[IDLE_BIT];
    end

  // Count unless frozen by power-down or wake hold; idle counts
  assign run = enabled_q & !pwr_q.power_down & !pwr_q.wake_hold;
  assign core_clk_en     = !pwr_q.power_down & !pwr_q.idle & !pwr_q.wake_hold;
  assign int_service_req = !int_level & !pwr_q.power_down & !pwr_q.wake_hold;

  wdtlp_counter u_counter
  (
    .pclk       (pclk),
    .presetn    (wd_rst_n),
    .run        (run),
    .restart    (service),
    .code       (code_q),
    .overflow_q (overflow)
  );

  // ****************************************
  // Overflow reset pulse
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pulse_on_q  <= 1'b0;
      pulse_cnt_q <= '0;
    end
    else if (overflow)
    begin
      pulse_on_q  <= 1'b1;
      pulse_cnt_q <= '0;
    end
    else if (pulse_on_q)
    begin
      if (pulse_cnt_q == RST_PULSE_LAST)
        pulse_on_q <= 1'b0;
      pulse_cnt_q <= pulse_cnt_q + 7'h01;
    end

  // Pin and internal reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      reset_pin_n <= 1'b1;
    else
      reset_pin_n <= !(overflow | (pulse_on_q & (pulse_cnt_q != RST_PULSE_LAST)));

  assign wd_rst_n = presetn & reset_pin_n;

  // Read data
  always_comb
  begin
    prdata = 32'h0000_0000;
    if (rd_en && hit_sel)
      prdata[7:0] = {RSVD_READ, code_q};
    else if (rd_en && hit_pwr)
    begin
      prdata[IDLE_BIT]    = pwr_q.idle;
      prdata[PD_BIT]      = pwr_q.power_down;
      prdata[ENABLED_BIT] = enabled_q;
      prdata[HELD_BIT]    = pwr_q.wake_hold;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_frozen_pd: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_q.power_down |-> !run) else $error("counter runs in power-down");
  a_hold_low: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_q.wake_hold && !int_level |=> !run) else $error("counter runs while line low");
  a_idle_runs: assert property (@(posedge pclk) disable iff (!wd_rst_n)
    enabled_q && pwr_q.idle && !pwr_q.power_down && !pwr_q.wake_hold |-> run)
    else $error("counter stopped in idle");
  a_no_isr_held: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_q.wake_hold |-> !int_service_req) else $error("wake interrupt serviced early");
  a_enable_sticky: assert property (@(posedge pclk) disable iff (!wd_rst_n)
    enabled_q |=> enabled_q) else $error("watchdog disabled without reset");
  a_key_enable: assert property (@(posedge pclk) disable iff (!wd_rst_n)
    service |=> enabled_q) else $error("key sequence did not enable");
  a_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> !reset_pin_n [*8]) else $error("reset pulse too short");
  a_pulse_ends: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(reset_pin_n) |-> ##[95:97] reset_pin_n) else $error("reset pulse length wrong");
  a_sel_read: assert property (@(posedge pclk) disable iff (!wd_rst_n)
    rd_en && hit_sel |-> prdata[2:0] == code_q) else $error("select readback wrong");
  a_sel_reset: assert property (@(posedge pclk)
    $rose(presetn) |-> code_q == CODE_RESET) else $error("select not reset");

  c_service: cover property (@(posedge pclk) disable iff (!presetn) service);
  c_overflow: cover property (@(posedge pclk) disable iff (!presetn) overflow);
  c_wake: cover property (@(posedge pclk) disable iff (!presetn) $fell(pwr_q.wake_hold));
  c_idle_count: cover property (@(posedge pclk) disable iff (!presetn) run && pwr_q.idle);
endmodule
`default_nettype wire

// ---- include/wdtlp_pkg.sv ----
`default_nettype none
package wdtlp_pkg;
  // ****************************************
  // Register map (APB byte addresses)
  // ****************************************
  localparam logic [7:0] SERVICE_KEY_IDX  = 8'ha6;  // Service key register index
  localparam logic [7:0] TIMEOUT_SEL_IDX  = 8'ha7;  // Timeout select register index
  localparam logic [7:0] POWER_CTRL_IDX   = 8'ha8;  // Power control / status index
  localparam logic [11:0] SERVICE_KEY_ADDR = {2'h0, SERVICE_KEY_IDX, 2'h0};
  localparam logic [11:0] TIMEOUT_SEL_ADDR = {2'h0, TIMEOUT_SEL_IDX, 2'h0};
  localparam logic [11:0] POWER_CTRL_ADDR  = {2'h0, POWER_CTRL_IDX, 2'h0};
  // ****************************************
  // Fields and values
  // ****************************************
  localparam int         CODE_W         = 3;
  localparam logic [2:0] CODE_RESET     = 3'h0;
  localparam logic [4:0] RSVD_READ      = 5'h00;  // Undetermined bits read as this
  localparam logic [7:0] KEY_FIRST      = 8'h1e;
  localparam logic [7:0] KEY_SECOND     = 8'he1;
  localparam int         PD_BIT         = 1;
  localparam int         IDLE_BIT       = 0;
  localparam int         ENABLED_BIT    = 2;
  localparam int         HELD_BIT       = 3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int          BASE_W        = 14;
  localparam logic [13:0] BASE_LAST     = 14'h3fff;
  localparam int          PRESC_W       = 7;
  localparam int          RST_PULSE_CLK = 96;
  localparam logic [6:0]  RST_PULSE_LAST = 7'(RST_PULSE_CLK - 1);
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wdtlp_apb_req_t;
  typedef struct packed {
    logic        power_down;
    logic        idle;
    logic        wake_hold;
  } wdtlp_pwr_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_ARMED} wdtlp_key_t;
endpackage
`default_nettype wire

// ---- logic/wdtlp_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module wdtlp_pin_sync
  import wdtlp_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output var  logic level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  // ****************************************
  // Three stages, change taken when last two agree
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  // Filtered level
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      level_q <= 1'b1;
    else if (s2_q == s3_q)
      level_q <= s3_q;
endmodule
`default_nettype wire

// ---- logic/wdtlp_counter.sv ----
`timescale 1ns/1ns
`default_nettype none
module wdtlp_counter
  import wdtlp_pkg::*;
#(
  parameter int BW = BASE_W,
  parameter int PW = PRESC_W
)
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          run,
  input  wire logic          restart,
  input  wire logic [2:0]    code,
  output var  logic          overflow_q
);
  logic [BW-1:0] base_q;
  logic [PW-1:0] presc_q;
  logic [PW-1:0] presc_mask;
  // Prescaler depth from code: 2^code base periods
  always_comb
    presc_mask = PW'((1 << code) - 1);
  // ****************************************
  // Base count and prescaler, cleared on restart
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      base_q     <= '0;
      presc_q    <= '0;
      overflow_q <= 1'b0;
    end
    else if (restart)
    begin
      base_q     <= '0;
      presc_q    <= '0;
      overflow_q <= 1'b0;
    end
    else
    begin
      overflow_q <= 1'b0;
      if (run)
      begin
        base_q <= base_q + 1'b1;
        if (base_q == BW'(BASE_LAST))
        begin
          if ((presc_q & presc_mask) == presc_mask)
          begin
            presc_q    <= '0;
            overflow_q <= 1'b1;
          end
          else
            presc_q <= presc_q + 1'b1;
        end
      end
    end
endmodule
`default_nettype wire

// ---- dv/tb_wdtlp_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_wdtlp_top
  import wdtlp_pkg::*;
;
  // ****************************************
  // Signals and device
  // ****************************************
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        ext_int_n;
  logic        ext_int_enabled;
  logic        int_service_req;
  logic        core_clk_en;
  logic        reset_pin_n;
  logic [31:0] rd_v;
  logic        err_v;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          t0;
  int          n;

  wdtlp_top uut (
    .pclk            (pclk),
    .presetn         (presetn),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .prdata          (prdata),
    .ext_int_n       (ext_int_n),
    .ext_int_enabled (ext_int_enabled),
    .int_service_req (int_service_req),
    .core_clk_en     (core_clk_en),
    .reset_pin_n     (reset_pin_n)
  );

  // Clock and cycle count
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      err_total++;
      finish_test();
    end
    rd_v    = prdata;
    err_v   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic service();
    bus(1'b1, SERVICE_KEY_ADDR, {24'h0, KEY_FIRST});
    bus(1'b1, SERVICE_KEY_ADDR, {24'h0, KEY_SECOND});
  endtask

  // Edges until the reset pulse shows, bounded
  task automatic time_to_low(input int lim);
    n = 0;
    while (reset_pin_n !== 1'b0 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim)
    begin
      err_total++;
      finish_test();
    end
  endtask

  task automatic pulse_width();
    n = 0;
    while (reset_pin_n === 1'b0 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n), 32'd96);
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    presetn         = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 12'h000;
    pwdata          = 32'h0;
    ext_int_n       = 1'b1;
    ext_int_enabled = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, every select code, refusals
    bus(1'b0, TIMEOUT_SEL_ADDR, 32'h0);
    chk(rd_v, {24'h0, RSVD_READ, CODE_RESET});
    bus(1'b0, POWER_CTRL_ADDR, 32'h0);
    chk({31'h0, rd_v[ENABLED_BIT]}, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, TIMEOUT_SEL_ADDR, 32'(c));
      bus(1'b0, TIMEOUT_SEL_ADDR, 32'h0);
      chk(rd_v, {24'h0, RSVD_READ, 3'(c)});
    end
    bus(1'b0, SERVICE_KEY_ADDR, 32'h0);
    chk({31'h0, err_v}, 32'h1);
    bus(1'b1, 12'h000, 32'h7);
    chk({31'h0, err_v}, 32'h1);
    // Broken key pair must not enable
    bus(1'b1, TIMEOUT_SEL_ADDR, 32'h0);
    bus(1'b1, SERVICE_KEY_ADDR, {24'h0, KEY_FIRST});
    bus(1'b1, SERVICE_KEY_ADDR, 32'h55);
    bus(1'b1, SERVICE_KEY_ADDR, {24'h0, KEY_SECOND});
    bus(1'b0, POWER_CTRL_ADDR, 32'h0);
    chk({31'h0, rd_v[ENABLED_BIT]}, 32'h0);
    // Code 0 overflow while idle
    service();
    t0 = cyc;
    bus(1'b0, POWER_CTRL_ADDR, 32'h0);
    chk({31'h0, rd_v[ENABLED_BIT]}, 32'h1);
    bus(1'b1, POWER_CTRL_ADDR, 32'h1 << IDLE_BIT);
    chk({31'h0, core_clk_en}, 32'h0);
    time_to_low(20000);
    chk(32'(cyc - t0 >= 16378 && cyc - t0 <= 16392), 32'h1);
    pulse_width();
    bus(1'b0, POWER_CTRL_ADDR, 32'h0);
    chk({31'h0, rd_v[ENABLED_BIT]}, 32'h0);
    // Code 1, restart, then no overflow in the next 20000 cycles
    bus(1'b1, TIMEOUT_SEL_ADDR, 32'h1);
    service();
    repeat (8000) @(posedge pclk);
    service();
    repeat (20000) @(posedge pclk);
    chk({31'h0, reset_pin_n}, 32'h1);
    // Code 0, serviced just before power-down, frozen until line high
    bus(1'b1, TIMEOUT_SEL_ADDR, 32'h0);
    service();
    bus(1'b1, POWER_CTRL_ADDR, 32'h1 << PD_BIT);
    ext_int_n <= 1'b0;
    repeat (1500) @(posedge pclk);
    chk({30'h0, core_clk_en, reset_pin_n}, 32'h1);
    ext_int_enabled <= 1'b1;
    repeat (1500) @(posedge pclk);
    bus(1'b0, POWER_CTRL_ADDR, 32'h0);
    chk(rd_v & 32'h8, 32'h8);
    chk({30'h0, int_service_req, reset_pin_n}, 32'h1);
    ext_int_n <= 1'b1;
    time_to_low(17000);
    chk(32'(n >= 16370 && n <= 16410), 32'h1);
    pulse_width();
    // After the overflow reset, enable again as after any reset
    service();
    // Idle with periodic wake, service and re-entry
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, POWER_CTRL_ADDR, 32'h1 << IDLE_BIT);
      repeat (6000) @(posedge pclk);
      ext_int_n <= 1'b0;
      repeat (8) @(posedge pclk);
      chk({30'h0, core_clk_en, int_service_req}, 32'h3);
      ext_int_n <= 1'b1;
      service();
    end
    chk({31'h0, reset_pin_n}, 32'h1);
    // Service in the routine after a power-down wake
    repeat (9000) @(posedge pclk);
    bus(1'b1, POWER_CTRL_ADDR, 32'h1 << PD_BIT);
    ext_int_n <= 1'b0;
    repeat (20) @(posedge pclk);
    ext_int_n <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({31'h0, core_clk_en}, 32'h1);
    service();
    repeat (9000) @(posedge pclk);
    chk({31'h0, reset_pin_n}, 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
